// [core/ffm_map.svh]
// Purpose: offsets, field positions, reset values and timing of the fan failure monitor
// Assumes: 32-bit APB, one register per aligned word
// Notes:   definitions only
`ifndef FFM_MAP_SVH
`define FFM_MAP_SVH

// register byte addresses
`define FFM_CFG_BASE      8'h00
`define FFM_LIMIT_BASE    8'h20
`define FFM_DUTY_BASE     8'h40
`define FFM_COUNT_BASE    8'h60
`define FFM_FAULT_ADDR    8'h80
`define FFM_MASK_ADDR     8'h84
`define FFM_OPT_ADDR      8'h88
`define FFM_CH_SPAN       8'h18

// channel configuration fields
`define FFM_CFG_ROLE      0
`define FFM_CFG_LRPOL     1
`define FFM_CFG_LRSEL     2
`define FFM_CFG_INEN      3
`define FFM_CFG_RANGE_LSB 4
`define FFM_CFG_RANGE_MSB 6
`define FFM_CFG_MODE      7

// options fields
`define FFM_OPT_QUEUE_LSB 0
`define FFM_OPT_QUEUE_MSB 2
`define FFM_OPT_ACT_LSB   4
`define FFM_OPT_ACT_MSB   5

// measured count second half lives at bit 16 of the count word
`define FFM_COUNT_PIN_LSB 16

// reset values
`define FFM_CFG_RST       8'h00
`define FFM_LIMIT_RST     11'h7FF
`define FFM_DUTY_RST      9'h000
`define FFM_MASK_RST      6'h00
`define FFM_QUEUE_RST     3'h1

// value limits
`define FFM_COUNT_MAX     11'h7FF
`define FFM_DUTY_FULL     9'h1FF
`define FFM_QUEUE_MAX     3'h6
`define FFM_RANGE_MAX     3'h5

// timing
`define FFM_PCLK_HZ       25000000
`define FFM_TICK_HZ       8192
`define FFM_MEAS_PERIOD_S 1

`endif

// [core/ffm_pkg.sv]
// Purpose: types of the fan failure monitor
// Assumes: six channels, each with a speed input and a drive pin
// Notes:   all module state is one packed struct
`include "ffm_map.svh"

package ffm_pkg;

    typedef enum logic [1:0] {
        FFM_ACT_KEEP,
        FFM_ACT_ZERO,
        FFM_ACT_FULL,
        FFM_ACT_RSVD
    } ffm_action_e;

    // one measurement engine per sensed line
    typedef struct packed {
        logic        armed;
        logic        done;
        logic [5:0]  periods;
        logic [10:0] ticks;
        logic        unlocked;
    } ffm_src_s;

    typedef struct packed {
        logic [5:0][7:0]   cfg;
        logic [5:0][10:0]  limit;
        logic [5:0][8:0]   duty;
        logic [11:0][10:0] meas;
        ffm_src_s [11:0]   src;
        logic [5:0][2:0]   qcnt;
        logic [5:0]        failed;
        logic [5:0]        mask;
        logic [2:0]        queue;
        ffm_action_e       action;
        logic [11:0]       tick_div;
        logic [15:0]       sec_cnt;
        logic [11:0]       sync1;
        logic [11:0]       sync2;
        logic [11:0]       prev;
        logic [31:0]       prdata;
        logic [5:0]        drive;
        logic [5:0]        drive_oe;
        logic              fail_oe;
    } ffm_state_s;

endpackage

// [core/ffm_monitor.sv]
// Purpose: six-channel fan speed measurement and fan failure detection, APB slave
// Assumes: pwm_level and duty_at_full come from the duty generator on pclk
//          measurement tick and second are divided down from pclk
// Notes:   engines 0..5 watch speed inputs, 6..11 watch drive pins
//          a failed fan stays failed until its limit or duty is written
//          pslverr marks unmapped and misaligned words
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "ffm_map.svh"

module ffm_monitor
    import ffm_pkg::*;
#(
    parameter int TICK_DIV     = `FFM_PCLK_HZ / `FFM_TICK_HZ,
    parameter int SECOND_TICKS = `FFM_TICK_HZ * `FFM_MEAS_PERIOD_S
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // duty generator side
    input  wire logic [5:0]  pwm_level,
    input  wire logic [5:0]  duty_at_full,
    // fan pins
    input  wire logic [5:0]  speed_pulse_input,
    input  wire logic [5:0]  fan_drive_output_in,
    output logic [5:0]       fan_drive_output_out,
    output logic [5:0]       fan_drive_output_oe,
    // open-drain failure pin, active low
    output logic             fan_fail_n_out,
    output logic             fan_fail_n_oe,
    // status
    output logic [5:0]       fan_failed
);

    ffm_state_s s_r;
    ffm_state_s s_nxt;
    logic       addr_ok;

    localparam logic [11:0] TICK_LAST = 12'(TICK_DIV - 1);
    localparam logic [15:0] SEC_LAST  = 16'(SECOND_TICKS - 1);

    // free running time base: a register write never moves the second
    // boundary, so every channel is evaluated on the same strobe

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic        tick;
        logic        second;
        logic        wr;
        logic        rd_setup;
        logic        hit;
        logic [31:0] rdata;
        logic [2:0]  idx;
        logic [7:0]  off;
        logic [5:0]  clr;
        logic [2:0]  range;
        logic [5:0]  target;
        logic [3:0]  ch;
        logic [10:0] mcnt;
        logic [11:0] lim2;
        logic [2:0]  need;
        logic [2:0]  base_cnt;
        logic        base_failed;
        logic        fault;
        logic        suppress;
        logic        rise;
        logic        locked;

        tick        = 1'b0;
        second      = 1'b0;
        wr          = 1'b0;
        rd_setup    = 1'b0;
        hit         = 1'b0;
        rdata       = 32'h0000_0000;
        idx         = 3'h0;
        off         = 8'h00;
        clr         = 6'h00;
        range       = 3'h0;
        target      = 6'h00;
        ch          = 4'h0;
        mcnt        = 11'h000;
        lim2        = 12'h000;
        need        = 3'h1;
        base_cnt    = 3'h0;
        base_failed = 1'b0;
        fault       = 1'b0;
        suppress    = 1'b0;
        rise        = 1'b0;
        locked      = 1'b0;

        s_nxt = s_r;

        // pins cross into pclk before any logic looks at them
        s_nxt.sync1 = {fan_drive_output_in, speed_pulse_input};
        s_nxt.sync2 = s_r.sync1;
        s_nxt.prev  = s_r.sync2;

        // measurement time base
        tick            = (s_r.tick_div == TICK_LAST);
        s_nxt.tick_div  = tick ? 12'h000 : s_r.tick_div + 12'h001;
        second          = tick && (s_r.sec_cnt == SEC_LAST);
        if (tick) begin
            s_nxt.sec_cnt = second ? 16'h0000 : s_r.sec_cnt + 16'h0001;
        end

        // apb address decode
        wr       = psel && penable && pwrite;
        rd_setup = psel && !penable;
        off      = paddr;
        if (paddr[1:0] != 2'b00) begin
            hit = 1'b0;
        end else if (paddr < `FFM_CFG_BASE + `FFM_CH_SPAN) begin
            hit   = 1'b1;
            off   = paddr - `FFM_CFG_BASE;
            idx   = off[4:2];
            rdata = {24'h000000, s_r.cfg[idx]};
            if (wr) begin
                s_nxt.cfg[idx] = pwdata[7:0];
            end
        end else if (paddr >= `FFM_LIMIT_BASE && paddr < `FFM_LIMIT_BASE + `FFM_CH_SPAN) begin
            hit   = 1'b1;
            off   = paddr - `FFM_LIMIT_BASE;
            idx   = off[4:2];
            rdata = {21'h000000, s_r.limit[idx]};
            if (wr) begin
                s_nxt.limit[idx] = pwdata[10:0];
                clr[idx]         = 1'b1;
            end
        end else if (paddr >= `FFM_DUTY_BASE && paddr < `FFM_DUTY_BASE + `FFM_CH_SPAN) begin
            hit   = 1'b1;
            off   = paddr - `FFM_DUTY_BASE;
            idx   = off[4:2];
            rdata = {23'h000000, s_r.duty[idx]};
            if (wr) begin
                s_nxt.duty[idx] = pwdata[8:0];
                clr[idx]        = 1'b1;
            end
        end else if (paddr >= `FFM_COUNT_BASE && paddr < `FFM_COUNT_BASE + `FFM_CH_SPAN) begin
            hit   = 1'b1;
            off   = paddr - `FFM_COUNT_BASE;
            idx   = off[4:2];
            // both halves come from one strobe, so the pair never tears
            rdata = {5'h00, s_r.meas[4'(idx) + 4'h6], 5'h00, s_r.meas[idx]};
        end else if (paddr == `FFM_FAULT_ADDR) begin
            hit   = 1'b1;
            rdata = {26'h0000000, s_r.failed};
        end else if (paddr == `FFM_MASK_ADDR) begin
            hit   = 1'b1;
            rdata = {26'h0000000, s_r.mask};
            if (wr) begin
                s_nxt.mask = pwdata[5:0];
            end
        end else if (paddr == `FFM_OPT_ADDR) begin
            hit   = 1'b1;
            rdata = {26'h0000000, s_r.action, 1'b0, s_r.queue};
            if (wr) begin
                s_nxt.queue  = pwdata[`FFM_OPT_QUEUE_MSB:`FFM_OPT_QUEUE_LSB];
                s_nxt.action = ffm_action_e'(pwdata[`FFM_OPT_ACT_MSB:`FFM_OPT_ACT_LSB]);
            end
        end else begin
            hit = 1'b0;
        end
        // read data is caught in the setup cycle so it stands from a flop
        // a count read set up on the strobe still sees the last second
        if (rd_setup) begin
            s_nxt.prdata = hit ? rdata : 32'h0000_0000;
        end

        // speed measurement, one engine per sensed line
        // a rise on the strobe cycle is lost with the engine clear;
        // the window then simply opens on the next rise
        for (int k = 0; k < 12; k++) begin
            ch     = (k < 6) ? 4'(k) : 4'(k - 6);
            range  = s_r.cfg[ch][`FFM_CFG_RANGE_MSB:`FFM_CFG_RANGE_LSB];
            if (range > `FFM_RANGE_MAX) begin
                range = `FFM_RANGE_MAX;
            end
            target = 6'h01 << range;
            rise   = s_r.sync2[k] && !s_r.prev[k];
            locked = (s_r.sync2[k] == s_r.cfg[ch][`FFM_CFG_LRPOL]);
            if (!locked) begin
                s_nxt.src[k].unlocked = 1'b1;
            end
            // first edge opens the window, the next 2^range edges close it
            if (rise && !s_r.src[k].armed) begin
                s_nxt.src[k].armed = 1'b1;
            end else if (rise && !s_r.src[k].done) begin
                s_nxt.src[k].periods = s_r.src[k].periods + 6'h01;
                if (s_r.src[k].periods + 6'h01 == target) begin
                    s_nxt.src[k].done = 1'b1;
                end
            end
            if (tick && s_r.src[k].armed && !s_r.src[k].done
                && s_r.src[k].ticks != `FFM_COUNT_MAX) begin
                s_nxt.src[k].ticks = s_r.src[k].ticks + 11'h001;
            end
            // a window not closed within the second reads as a stopped fan
            if (second) begin
                s_nxt.meas[k] = s_r.src[k].done ? s_r.src[k].ticks : `FFM_COUNT_MAX;
                s_nxt.src[k]  = '0;
            end
        end

        // failure evaluation once per second per channel
        // qcnt counts faulty seconds in a row; a clean or suppressed
        // second starts it over
        for (int c = 0; c < 6; c++) begin
            // queue 0 acts as 1, anything above 6 as 6
            need = s_r.queue;
            if (need == 3'h0) begin
                need = 3'h1;
            end else if (need > `FFM_QUEUE_MAX) begin
                need = `FFM_QUEUE_MAX;
            end
            // a write restarts the process, but a same-cycle detection still counts
            base_cnt    = clr[c] ? 3'h0 : s_r.qcnt[c];
            base_failed = clr[c] ? 1'b0 : s_r.failed[c];
            s_nxt.qcnt[c]   = base_cnt;
            s_nxt.failed[c] = base_failed;

            fault    = 1'b0;
            suppress = !s_r.cfg[c][`FFM_CFG_INEN];
            if (s_r.cfg[c][`FFM_CFG_MODE]) begin
                suppress = suppress || (s_r.limit[c] == `FFM_COUNT_MAX);
            end else begin
                suppress = suppress || (s_r.duty[c] == 9'h000);
            end

            if (s_r.cfg[c][`FFM_CFG_LRSEL]) begin
                // locked rotor: the level never left the locked state all second
                fault = !s_r.src[c].unlocked;
                if (s_r.cfg[c][`FFM_CFG_ROLE]) begin
                    fault = fault || !s_r.src[c + 6].unlocked;
                end
            end else begin
                mcnt = s_nxt.meas[c];
                lim2 = {s_r.limit[c], 1'b0};
                if (s_r.cfg[c][`FFM_CFG_MODE]) begin
                    fault = (duty_at_full[c] && mcnt > s_r.limit[c])
                         || (!duty_at_full[c] && {1'b0, mcnt} > lim2)
                         || (mcnt == `FFM_COUNT_MAX);
                end else begin
                    fault = (mcnt > s_r.limit[c]);
                end
                if (s_r.cfg[c][`FFM_CFG_ROLE]) begin
                    fault = fault || (s_nxt.meas[c + 6] > s_r.limit[c]);
                end
            end

            // first excess is only a potential fault: failure needs queue more
            if (second && !base_failed) begin
                if (suppress || !fault) begin
                    s_nxt.qcnt[c] = 3'h0;
                end else if (base_cnt >= need) begin
                    s_nxt.qcnt[c]   = base_cnt + 3'h1;
                    s_nxt.failed[c] = 1'b1;
                end else begin
                    s_nxt.qcnt[c] = base_cnt + 3'h1;
                end
            end

            // drive pin: input when the role bit is set, else policy-gated drive
            // the policy follows the failed flag one cycle later
            s_nxt.drive_oe[c] = !s_r.cfg[c][`FFM_CFG_ROLE];
            s_nxt.drive[c]    = pwm_level[c];
            if (s_r.failed[c]) begin
                case (s_r.action)
                    FFM_ACT_ZERO: begin
                        s_nxt.drive[c] = 1'b0;
                    end
                    FFM_ACT_FULL: begin
                        s_nxt.drive[c] = 1'b1;
                    end
                    default: begin
                        s_nxt.drive[c] = pwm_level[c];
                    end
                endcase
            end
        end

        // pin and flags change on the same edge
        s_nxt.fail_oe = |(s_nxt.failed & ~s_nxt.mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    // reset drives every drive pin and flags no fan; detection waits until
    // software sets an input enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r        <= '0;
            s_r.cfg    <= {6{`FFM_CFG_RST}};
            s_r.limit  <= {6{`FFM_LIMIT_RST}};
            s_r.duty   <= {6{`FFM_DUTY_RST}};
            s_r.mask   <= `FFM_MASK_RST;
            s_r.queue  <= `FFM_QUEUE_RST;
            s_r.action <= FFM_ACT_KEEP;
            s_r.drive_oe <= 6'h3F;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // same map as the register decode, kept apart so that pslverr
    // stays a plain function of the bus and needs no state
    always_comb begin
        addr_ok = 1'b0;
        if (paddr[1:0] != 2'b00) begin
            addr_ok = 1'b0;
        end else if (paddr < `FFM_CFG_BASE + `FFM_CH_SPAN) begin
            addr_ok = 1'b1;
        end else if (paddr >= `FFM_LIMIT_BASE && paddr < `FFM_LIMIT_BASE + `FFM_CH_SPAN) begin
            addr_ok = 1'b1;
        end else if (paddr >= `FFM_DUTY_BASE && paddr < `FFM_DUTY_BASE + `FFM_CH_SPAN) begin
            addr_ok = 1'b1;
        end else if (paddr >= `FFM_COUNT_BASE && paddr < `FFM_COUNT_BASE + `FFM_CH_SPAN) begin
            addr_ok = 1'b1;
        end else if (paddr == `FFM_FAULT_ADDR || paddr == `FFM_MASK_ADDR) begin
            addr_ok = 1'b1;
        end else if (paddr == `FFM_OPT_ADDR) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // zero wait states; unmapped or misaligned words answer with pslverr
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    // open drain: the value is fixed low, only the enable moves
    assign prdata               = s_r.prdata;
    assign fan_drive_output_out = s_r.drive;
    assign fan_drive_output_oe  = s_r.drive_oe;
    assign fan_fail_n_out       = 1'b0;
    assign fan_fail_n_oe        = s_r.fail_oe;
    assign fan_failed           = s_r.failed;

endmodule

// [sim/ffm_fan_model.sv]
// Purpose: fans on the six speed inputs and six drive pins
// Assumes: one shared pulse rate, per-line stall at a chosen level
// Notes:   a drive pin shows the device level only while its oe is high
`timescale 1ns/1ps

module ffm_fan_model
    import ffm_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // fan behaviour
    input  wire logic [7:0] half_period,
    input  wire logic [5:0] stall_spd,
    input  wire logic [5:0] stall_drv,
    input  wire logic       stall_lvl,
    // device drive pins
    input  wire logic [5:0] drive_out,
    input  wire logic [5:0] drive_oe,
    // wire levels seen by the device
    output logic [5:0]      speed_line,
    output logic [5:0]      drive_line
);
    logic [7:0] cnt;
    logic       ph;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
            ph  <= 1'b0;
        end else if (cnt + 8'h01 >= half_period) begin
            cnt <= 8'h00;
            ph  <= !ph;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

    // a stalled fan holds its line: no pulses, or a locked-rotor level
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            speed_line[i] = stall_spd[i] ? stall_lvl : ph;
            drive_line[i] = drive_oe[i] ? drive_out[i] : (stall_drv[i] ? stall_lvl : ph);
        end
    end
endmodule

// [sim/ffm_monitor_sva.sv]
// Purpose: port checks of the fan failure monitor
// Assumes: mask and options shadowed from apb writes
// Notes:   bound into every ffm_monitor
`timescale 1ns/1ps
`include "ffm_map.svh"

module ffm_monitor_sva
    import ffm_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins and status
    input wire logic [5:0]  fan_drive_output_out,
    input wire logic        fan_fail_n_out,
    input wire logic        fan_fail_n_oe,
    input wire logic [5:0]  fan_failed
);
    logic       wr;
    logic       ctl_hit;
    logic [5:0] mask_r;
    logic [5:0] opt_r;

    assign wr = psel && penable && pwrite && pready;
    // limit 20h..34h and duty 40h..54h share the channel index in [4:2]
    assign ctl_hit = wr && paddr[1:0] == 2'h0 && paddr[4:2] < 3'h6
                     && (paddr[7:5] == 3'h1 || paddr[7:5] == 3'h2);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= 6'h00;
            opt_r  <= 6'h01;
        end else if (wr && paddr == `FFM_MASK_ADDR) begin
            mask_r <= pwdata[5:0];
        end else if (wr && paddr == `FFM_OPT_ADDR) begin
            opt_r <= pwdata[5:0];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////
    property p_out_low; fan_fail_n_out == 1'b0; endproperty
    property p_fail_pin;
        $stable(fan_failed) && $stable(mask_r) |-> fan_fail_n_oe == |(fan_failed & ~mask_r);
    endproperty
    property p_clear; ctl_hit |=> !fan_failed[$past(paddr[4:2])]; endproperty
    property p_sticky; |($past(fan_failed) & ~fan_failed) |-> $past(ctl_hit); endproperty
    property p_force0;
        opt_r[5:4] == 2'h1 && $stable(opt_r)
            |-> (fan_failed & $past(fan_failed) & fan_drive_output_out) == 6'h00;
    endproperty
    property p_force1;
        opt_r[5:4] == 2'h2 && $stable(opt_r)
            |-> (fan_failed & $past(fan_failed) & ~fan_drive_output_out) == 6'h00;
    endproperty
    property p_err;
        psel && penable && (paddr[1:0] != 2'h0 || paddr > 8'h88)
            |-> pready && pslverr && (pwrite || prdata == 32'h0);
    endproperty
    property p_count;
        psel && penable && !pwrite && paddr >= 8'h60 && paddr < 8'h78
            |-> prdata[15:11] == 5'h00 && prdata[31:27] == 5'h00;
    endproperty

    a_out_low: assert property (p_out_low) else $error("fail pin value not low");
    a_fail_pin: assert property (p_fail_pin) else $error("fail pin wrong");
    a_clear: assert property (p_clear) else $error("failed flag kept after write");
    a_sticky: assert property (p_sticky) else $error("failed flag dropped");
    a_force0: assert property (p_force0) else $error("failed fan not held low");
    a_force1: assert property (p_force1) else $error("failed fan not held high");
    a_err: assert property (p_err) else $error("bad address not refused");
    a_count: assert property (p_count) else $error("count wider than 11 bits");

    c_fail: cover property ($rose(fan_failed[0]));
    c_clear: cover property (ctl_hit && fan_failed[0]);
    c_mask: cover property (fan_failed[0] && mask_r[0]);
endmodule

bind ffm_monitor ffm_monitor_sva u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fan_drive_output_out(fan_drive_output_out), .fan_fail_n_out(fan_fail_n_out),
    .fan_fail_n_oe(fan_fail_n_oe), .fan_failed(fan_failed)
);

// [sim/fan_failure_monitor_bench.sv]
// Purpose: self-checking bench of the fan failure monitor
// Assumes: short second of 128 clocks, fault queue of two
// Notes:   channel 0 carries the cases, the others keep pulsing
`timescale 1ns/1ps
`include "ffm_map.svh"

module fan_failure_monitor_bench
    import ffm_pkg::*;
;
    localparam int SEC = 128;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        fail_out, fail_oe, st_lvl;
    logic [7:0]  paddr, half;
    logic [31:0] pwdata, prdata, rd;
    logic [31:0] seed = 32'hF5E36B02;
    logic [5:0]  pwm_level, duty_at_full, spd, drv_in, drv_out, drv_oe, fan_failed;
    logic [5:0]  st_spd, st_drv;
    int          n_errors, check_count;

    ffm_monitor #(.TICK_DIV(2), .SECOND_TICKS(64)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwm_level(pwm_level), .duty_at_full(duty_at_full), .speed_pulse_input(spd),
        .fan_drive_output_in(drv_in), .fan_drive_output_out(drv_out),
        .fan_drive_output_oe(drv_oe), .fan_fail_n_out(fail_out), .fan_fail_n_oe(fail_oe),
        .fan_failed(fan_failed));
    ffm_fan_model fans (
        .pclk(pclk), .presetn(presetn), .half_period(half), .stall_spd(st_spd),
        .stall_drv(st_drv), .stall_lvl(st_lvl), .drive_out(drv_out), .drive_oe(drv_oe),
        .speed_line(spd), .drive_line(drv_in));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // st[0] stalls the speed input, st[1] the drive pin of channel 0
    task automatic run_case(input logic [7:0] cfg, input logic [10:0] lim,
                            input logic [8:0] duty, input logic full, input logic [1:0] st,
                            input logic lvl, input logic exp);
        logic [7:0] h;
        h = 8'h10 + {5'h00, seed[2:0]};
        @(posedge pclk);
        half         <= h;
        st_spd       <= {5'h00, st[0]};
        st_drv       <= {5'h00, st[1]};
        st_lvl       <= lvl;
        duty_at_full <= {5'h00, full};
        apb(1'b1, `FFM_CFG_BASE, {24'h0, cfg});
        apb(1'b1, `FFM_LIMIT_BASE, {21'h0, lim});
        apb(1'b1, `FFM_DUTY_BASE, {23'h0, duty});
        tick(5 * SEC);
        chk("failed", 32'(exp), 32'(fan_failed[0]));
        apb(1'b0, `FFM_FAULT_ADDR, 32'h0);
        chk("fault reg", 32'(exp), rd);
        chk("drive oe", 32'(!cfg[0]), 32'(drv_oe[0]));
        if (cfg[2] == 1'b0 && st == 2'b00) begin
            apb(1'b0, `FFM_COUNT_BASE, 32'h0);
            chk("count", {24'h0, h}, rd & 32'hF800FFFF);
        end
        if (exp) begin
            chk("fail pin", 32'h1, 32'(fail_oe));
            apb(1'b1, `FFM_MASK_ADDR, 32'h1);
            tick(2);
            chk("masked pin", 32'h0, 32'(fail_oe));
            for (int a = 1; a < 3 && !cfg[0]; a++) begin
                apb(1'b1, `FFM_OPT_ADDR, 32'(a << 4) | 32'h2);
                tick(2);
                chk("forced drive", 32'(a == 2), 32'(drv_out[0]));
            end
            apb(1'b1, `FFM_OPT_ADDR, 32'h2);
            apb(1'b1, `FFM_MASK_ADDR, 32'h0);
            apb(1'b1, `FFM_DUTY_BASE, {23'h0, duty});
            #1;
            chk("cleared", 32'h0, 32'(fan_failed[0]));
            // queue two: first excess after the write plus two more in a row
            tick(250);
            chk("too early", 32'h0, 32'(fan_failed[0]));
            tick(140);
            chk("failed again", 32'h1, 32'(fan_failed[0]));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        seed      <= xs(seed);
        pwm_level <= seed[5:0];
    end

    initial begin
        repeat (30000) @(posedge pclk);
        n_errors++;
        stop_test();
    end

    initial begin
        logic [7:0]  ra [5];
        logic [31:0] rv [5];
        ra = '{`FFM_CFG_BASE, `FFM_LIMIT_BASE, `FFM_DUTY_BASE, `FFM_OPT_ADDR, 8'h8C};
        rv = '{32'h0, 32'h7FF, 32'h0, 32'h1, 32'h0};
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {duty_at_full, st_spd, st_drv, st_lvl} = '0;
        half = 8'h10;
        n_errors = 0;
        check_count = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ra[i], 32'h0);
            chk("reset read", rv[i], rd);
            chk("slave error", 32'(i == 4), 32'(err));
        end
        apb(1'b1, `FFM_OPT_ADDR, 32'h2);
        run_case(8'h08, 11'h005, 9'h064, 1'b0, 2'b00, 1'b0, 1'b1);
        run_case(8'h08, 11'h0C8, 9'h064, 1'b0, 2'b00, 1'b0, 1'b0);
        run_case(8'h08, 11'h005, 9'h000, 1'b0, 2'b00, 1'b0, 1'b0);
        run_case(8'h88, 11'h00F, 9'h064, 1'b1, 2'b00, 1'b0, 1'b1);
        run_case(8'h88, 11'h00F, 9'h064, 1'b0, 2'b00, 1'b0, 1'b0);
        run_case(8'h88, 11'h007, 9'h064, 1'b0, 2'b00, 1'b0, 1'b1);
        run_case(8'h88, 11'h7FF, 9'h064, 1'b0, 2'b01, 1'b0, 1'b0);
        run_case(8'h88, 11'h400, 9'h064, 1'b0, 2'b01, 1'b0, 1'b1);
        run_case(8'h0E, 11'h0C8, 9'h064, 1'b0, 2'b01, 1'b1, 1'b1);
        run_case(8'h0C, 11'h0C8, 9'h064, 1'b0, 2'b01, 1'b1, 1'b0);
        run_case(8'h09, 11'h0C8, 9'h064, 1'b0, 2'b10, 1'b0, 1'b1);
        stop_test();
    end
endmodule
